// *** bvf_video_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module bvf_video_top
  import bvf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic POWER_ON_CLEAR_N,
  input wire logic TIMING_CTRL_SELECT,
  input wire logic BUS_PHASE_STROBE,
  input wire logic REGISTER_SELECT_BIT,
  input wire logic HOST_READ_NOT_WRITE,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  output logic [7:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE,
  input wire logic CPU_OWNS_VIDEO_MEMORY,
  input wire logic [15:0] CPU_ADDRESS,
  input wire logic CPU_ACCESS_SELECT,
  input wire logic CLEAR_SCREEN_LINE,
  input wire logic [1:0] MEMORY_SIZE_OPTION,
  input wire logic [7:0] RED_PLANE_DATA,
  input wire logic [7:0] GREEN_PLANE_DATA,
  input wire logic [7:0] BLUE_PLANE_DATA,
  input wire logic RED_PLANE_GATE,
  input wire logic GREEN_PLANE_GATE,
  input wire logic BLUE_PLANE_GATE,
  input wire logic SOLID_FILL,
  output logic [15:0] VIDEO_MEMORY_ADDRESS,
  output logic [7:0] DRAM_MUX_ADDRESS,
  output logic ROW_COLUMN_SELECT,
  output logic VIDEO_MEMORY_WRITE_EN,
  output logic CPU_WAIT,
  output logic PIXEL_LATCH_STROBE,
  output logic SHIFT_LOAD_N,
  output logic DISPLAY_WINDOW_ENABLE,
  output logic HSYNC_OUT,
  output logic VSYNC_OUT,
  output logic VSYNC_IRQ,
  output logic RED_OUTPUT,
  output logic GREEN_OUTPUT,
  output logic BLUE_OUTPUT
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True when pos lies in [start, start + width); width zero means empty.
  function automatic logic in_band(input logic [7:0] pos, input logic [7:0] start,
                                   input logic [7:0] width);
    logic [8:0] end_pos;
    end_pos = {1'b0, start} + {1'b0, width};
    in_band = ({1'b0, pos} >= {1'b0, start}) && ({1'b0, pos} < end_pos);
  endfunction

  // ==========================================================================
  // Host register port
  // ==========================================================================
  logic [7:0] regs_ff [0:17];
  logic [4:0] index_ff;
  logic strobe_prev_ff;
  logic [7:0] host_out_ff;
  logic host_oe_ff;
  wire regs_clear = !RST_N || !POWER_ON_CLEAR_N;
  wire strobe_fall = strobe_prev_ff && !BUS_PHASE_STROBE;
  wire host_take = strobe_fall && TIMING_CTRL_SELECT;
  wire index_load = host_take && !REGISTER_SELECT_BIT;
  wire index_valid = index_ff < 5'(BVF_NUM_REGS);
  wire data_write = host_take && REGISTER_SELECT_BIT && !HOST_READ_NOT_WRITE && index_valid;
  wire [7:0] indexed_value = index_valid ? regs_ff[index_ff] : 8'h00;

  // The index register sits outside the eighteen and is cleared with them.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      index_ff <= '0;
      strobe_prev_ff <= 1'b0;
    end else if (CLK_EN) begin
      strobe_prev_ff <= BUS_PHASE_STROBE;
      if (index_load) begin
        index_ff <= HOST_DATA_BUS_IN[4:0];
      end
    end
  end

  // A host write lands in whichever register the index points at.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      regs_ff <= BVF_REG_INIT;
    end else if (CLK_EN && data_write) begin
      regs_ff[index_ff] <= HOST_DATA_BUS_IN;
    end
  end

  // Read data is driven, one cycle late, whenever a register read is selected, at either strobe level.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      host_out_ff <= 8'h00;
      host_oe_ff <= 1'b0;
    end else if (CLK_EN) begin
      host_out_ff <= indexed_value;
      host_oe_ff <= TIMING_CTRL_SELECT && REGISTER_SELECT_BIT && HOST_READ_NOT_WRITE;
    end
  end

  // ==========================================================================
  // Dot and character timing
  // ==========================================================================
  logic [2:0] dot_ff;
  wire char_tick = (dot_ff == DOT_LAST);

  // Each enabled system clock is one dot, eight dots make a character.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      dot_ff <= '0;
    end else if (CLK_EN) begin
      dot_ff <= dot_ff + 3'h1;
    end
  end

  // ==========================================================================
  // Raster scan counters
  // ==========================================================================
  logic [7:0] col_ff;
  logic [4:0] row_ff;
  logic [6:0] line_ff;
  logic [11:0] char_addr_ff;
  logic [11:0] base_ff;
  logic irq_ff;
  wire [11:0] start_addr = {regs_ff[REG_START_HI][3:0], regs_ff[REG_START_LO]};
  wire [11:0] cursor_addr = {regs_ff[REG_CURSOR_HI][3:0], regs_ff[REG_CURSOR_LO]};
  wire line_end = (col_ff == regs_ff[REG_H_TOTAL]);
  wire last_row = (row_ff == regs_ff[REG_MAX_SCAN_ROW][4:0]);
  wire frame_end = (line_ff == regs_ff[REG_V_TOTAL][6:0]);
  wire last_shown = ({1'b0, line_ff} + 8'h01 == regs_ff[REG_V_DISPLAYED]);
  wire h_shown = (col_ff < regs_ff[REG_H_DISPLAYED]);
  wire h_stop = ({1'b0, col_ff} + 9'h001 >= {1'b0, regs_ff[REG_H_DISPLAYED]});
  wire v_shown = ({1'b0, line_ff} < regs_ff[REG_V_DISPLAYED]);
  wire window_on = h_shown && v_shown;
  wire hsync_on = in_band(col_ff, regs_ff[REG_H_SYNC_POS], {4'h0, regs_ff[REG_SYNC_WIDTH][3:0]});
  wire vsync_on = ({1'b0, line_ff} == regs_ff[REG_V_SYNC_POS]);
  wire vsync_start = char_tick && line_end && last_row &&
                     ({1'b0, line_ff} + 8'h01 == regs_ff[REG_V_SYNC_POS]);
  wire [7:0] row_span = regs_ff[REG_CURSOR_END] - {3'h0, regs_ff[REG_CURSOR_START][4:0]} + 8'h01;
  wire cursor_on = window_on && (char_addr_ff == cursor_addr) &&
                   in_band({3'h0, row_ff}, {3'h0, regs_ff[REG_CURSOR_START][4:0]}, row_span);

  logic [7:0] nxt_col;
  logic [4:0] nxt_row;
  logic [6:0] nxt_line;
  logic [11:0] nxt_char_addr;
  logic [11:0] nxt_base;

  // Next raster position; counters move only on a character boundary.
  always_comb begin
    nxt_col = col_ff + 8'h01;
    nxt_row = row_ff;
    nxt_line = line_ff;
    nxt_base = base_ff;
    nxt_char_addr = h_stop ? char_addr_ff : char_addr_ff + 12'h001;
    if (line_end) begin
      nxt_col = 8'h00;
      nxt_row = row_ff + 5'h01;
      nxt_char_addr = base_ff;
      if (last_row) begin
        nxt_row = 5'h00;
        nxt_line = frame_end ? 7'h00 : line_ff + 7'h01;
        nxt_base = base_ff + {4'h0, regs_ff[REG_H_DISPLAYED]};
        if (last_shown || frame_end) begin
          nxt_base = start_addr;
        end
        nxt_char_addr = nxt_base;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      col_ff <= '0;
      row_ff <= '0;
      line_ff <= '0;
      char_addr_ff <= '0;
      base_ff <= '0;
    end else if (CLK_EN && char_tick) begin
      col_ff <= nxt_col;
      row_ff <= nxt_row;
      line_ff <= nxt_line;
      char_addr_ff <= nxt_char_addr;
      base_ff <= nxt_base;
    end
  end

  // Vertical retrace raises one interrupt pulse so software may reprogram
  // registers, for example the start address to scroll, off screen.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      irq_ff <= 1'b0;
    end else if (CLK_EN) begin
      irq_ff <= vsync_start;
    end
  end

  // ==========================================================================
  // Video memory address path
  // ==========================================================================
  logic [15:0] vaddr_ff;
  logic [7:0] dram_addr_ff;
  logic rc_sel_ff;
  logic we_ff;
  logic wait_ff;
  logic [2:0] dot_next;
  wire [15:0] scan_addr = {char_addr_ff, row_ff[3:0]};
  wire [15:0] mux_addr = CPU_OWNS_VIDEO_MEMORY ? CPU_ADDRESS : scan_addr;
  wire size_upper = (MEMORY_SIZE_OPTION == 2'(SIZE_32K_UPPER));
  wire size_lower = (MEMORY_SIZE_OPTION == 2'(SIZE_32K_LOWER));
  wire top_bit = size_upper ? 1'b1 : (size_lower ? 1'b0 : vaddr_ff[15]);
  // Row phase uses the fastest-moving scan bits, so scanning refreshes DRAM.
  wire [7:0] row_phase = {vaddr_ff[9:4], vaddr_ff[1], vaddr_ff[2]};
  wire [7:0] col_phase = {top_bit, vaddr_ff[14:10], vaddr_ff[3], vaddr_ff[0]};
  wire video_busy = window_on;
  wire cpu_writes = CPU_ACCESS_SELECT || CLEAR_SCREEN_LINE;

  assign dot_next = dot_ff + 3'h1;

  // The scan address is held for the whole character, a processor address follows each cycle; row phase leads.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      vaddr_ff <= '0;
      dram_addr_ff <= '0;
      rc_sel_ff <= 1'b0;
    end else if (CLK_EN) begin
      vaddr_ff <= mux_addr;
      rc_sel_ff <= (dot_next <= DOT_ROW_PHASE_END);
      dram_addr_ff <= (dot_next <= DOT_ROW_PHASE_END) ? row_phase : col_phase;
    end
  end

  // Display fetch has priority: the host waits and cannot write meanwhile.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      we_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else if (CLK_EN) begin
      we_ff <= cpu_writes && CPU_OWNS_VIDEO_MEMORY && !video_busy;
      wait_ff <= CPU_OWNS_VIDEO_MEMORY && video_busy;
    end
  end

  // ==========================================================================
  // Fetch strobes and serializer
  // ==========================================================================
  logic strobe_ff;
  logic load_n_ff;
  bvf_pix_if pix (.clk(CLK_SYS), .rst_n(!regs_clear));

  // Latch strobe sits in dot 6, load in dot 7, right before the last dot ends.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      strobe_ff <= 1'b0;
      load_n_ff <= 1'b1;
    end else if (CLK_EN) begin
      strobe_ff <= (dot_ff == DOT_STROBE_PREV);
      load_n_ff <= !(dot_ff == DOT_LOAD_PREV);
    end
  end

  assign pix.ce = CLK_EN;
  assign pix.latch_strobe = strobe_ff;
  assign pix.load = !load_n_ff;
  assign pix.plane_byte = {BLUE_PLANE_DATA, GREEN_PLANE_DATA, RED_PLANE_DATA};

  bvf_dot_shifter #(.PLANES(3)) u_shifter (
    .pix(pix.shifter)
  );

  // ==========================================================================
  // Attribute gating and aligned blanking
  // ==========================================================================
  logic [1:0] de_pipe_ff;
  logic [1:0] cur_pipe_ff;
  logic [2:0] color_ff;
  logic de_ff;
  logic hs_ff;
  logic vs_ff;
  wire [2:0] plane_gate = {BLUE_PLANE_GATE, GREEN_PLANE_GATE, RED_PLANE_GATE};
  wire [2:0] plane_dots = plane_gate & ({3{SOLID_FILL}} | pix.dots);
  // Without the two-character delay the last two characters would blank.
  wire [2:0] nxt_color = {3{de_pipe_ff[1]}} & ({3{cur_pipe_ff[1]}} | plane_dots);

  // Enable and cursor travel two characters to match the shifter latency.
  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      de_pipe_ff <= '0;
      cur_pipe_ff <= '0;
    end else if (CLK_EN && char_tick) begin
      de_pipe_ff <= {de_pipe_ff[0], window_on};
      cur_pipe_ff <= {cur_pipe_ff[0], cursor_on};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (regs_clear) begin
      color_ff <= '0;
      de_ff <= 1'b0;
      hs_ff <= 1'b0;
      vs_ff <= 1'b0;
    end else if (CLK_EN) begin
      color_ff <= nxt_color;
      de_ff <= window_on;
      hs_ff <= hsync_on;
      vs_ff <= vsync_on;
    end
  end

  assign HOST_DATA_BUS_OUT = host_out_ff;
  assign HOST_DATA_BUS_OE = host_oe_ff;
  assign VIDEO_MEMORY_ADDRESS = vaddr_ff;
  assign DRAM_MUX_ADDRESS = dram_addr_ff;
  assign ROW_COLUMN_SELECT = rc_sel_ff;
  assign VIDEO_MEMORY_WRITE_EN = we_ff;
  assign CPU_WAIT = wait_ff;
  assign PIXEL_LATCH_STROBE = strobe_ff;
  assign SHIFT_LOAD_N = load_n_ff;
  assign DISPLAY_WINDOW_ENABLE = de_ff;
  assign HSYNC_OUT = hs_ff;
  assign VSYNC_OUT = vs_ff;
  assign VSYNC_IRQ = irq_ff;
  assign RED_OUTPUT = color_ff[0];
  assign GREEN_OUTPUT = color_ff[1];
  assign BLUE_OUTPUT = color_ff[2];

endmodule

`default_nettype wire

// *** bvf_pkg.sv ***
package bvf_pkg;

  // ==========================================================================
  // Timing controller register file
  // ==========================================================================
  localparam int BVF_NUM_REGS = 18;
  localparam logic [4:0] REG_H_TOTAL = 5'h00;
  localparam logic [4:0] REG_H_DISPLAYED = 5'h01;
  localparam logic [4:0] REG_H_SYNC_POS = 5'h02;
  localparam logic [4:0] REG_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] REG_V_TOTAL = 5'h04;
  localparam logic [4:0] REG_V_DISPLAYED = 5'h06;
  localparam logic [4:0] REG_V_SYNC_POS = 5'h07;
  localparam logic [4:0] REG_MAX_SCAN_ROW = 5'h09;
  localparam logic [4:0] REG_CURSOR_START = 5'h0A;
  localparam logic [4:0] REG_CURSOR_END = 5'h0B;
  localparam logic [4:0] REG_START_HI = 5'h0C;
  localparam logic [4:0] REG_START_LO = 5'h0D;
  localparam logic [4:0] REG_CURSOR_HI = 5'h0E;
  localparam logic [4:0] REG_CURSOR_LO = 5'h0F;

  // Power-on values give the normal 80 x 25 character layout, 10 rows tall.
  localparam logic [7:0] BVF_REG_INIT [0:17] = '{
    8'h63, 8'h50, 8'h55, 8'h0A, 8'h1C, 8'h00, 8'h19, 8'h1A, 8'h00,
    8'h09, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // ==========================================================================
  // Dot and character timing
  // ==========================================================================
  localparam int BVF_DOTS_PER_CHAR = 8;
  localparam logic [2:0] DOT_STROBE_PREV = 3'h5;
  localparam logic [2:0] DOT_LOAD_PREV = 3'h6;
  localparam logic [2:0] DOT_LAST = 3'h7;
  localparam logic [2:0] DOT_ROW_PHASE_END = 3'h2;
  localparam int BVF_DOT_CLOCK_KHZ = 14112;
  localparam int BVF_SYS_CLOCK_KHZ = 20000;
  localparam int BVF_DISPLAY_DELAY_CHARS = 2;

  // ==========================================================================
  // Memory size option
  // ==========================================================================
  typedef enum logic [1:0] {
    SIZE_64K,
    SIZE_32K_UPPER,
    SIZE_32K_LOWER
  } bvf_size_e;

endpackage

// *** bvf_pix_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// Carries fetched plane bytes and their strobes to the dot shifter.
interface bvf_pix_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic ce;
  logic latch_strobe;
  logic load;
  logic [2:0][7:0] plane_byte;
  logic [2:0] dots;

  modport fetch (output ce, output latch_strobe, output load, output plane_byte, input dots);
  modport shifter (input clk, input rst_n, input ce, input latch_strobe, input load,
                   input plane_byte, output dots);
endinterface

`default_nettype wire

// *** bvf_dot_shifter.sv ***
`timescale 1ns/1ns
`default_nettype none

module bvf_dot_shifter
  import bvf_pkg::*;
#(
  parameter int PLANES = 3
) (
  bvf_pix_if.shifter pix
);

  // ==========================================================================
  // Holding latches and parallel-to-serial shifters
  // ==========================================================================
  logic [PLANES-1:0][7:0] hold_ff;
  logic [PLANES-1:0][7:0] shift_ff;
  logic [PLANES-1:0][7:0] nxt_hold;
  logic [PLANES-1:0][7:0] nxt_shift;

  // The latch takes the next byte while the shifter still empties the old one.
  assign nxt_hold = pix.latch_strobe ? pix.plane_byte : hold_ff;

  // Load arrives only in the last dot slot, so no dot is cut short.
  generate
    for (genvar p = 0; p < PLANES; p++) begin : g_plane
      assign nxt_shift[p] = pix.load ? hold_ff[p] : {shift_ff[p][6:0], 1'b0};
      assign pix.dots[p] = shift_ff[p][7];
    end
  endgenerate

  // All state halts while the clock enable is low.
  always_ff @(posedge pix.clk) begin
    if (!pix.rst_n) begin
      hold_ff <= '0;
      shift_ff <= '0;
    end else if (pix.ce) begin
      hold_ff <= nxt_hold;
      shift_ff <= nxt_shift;
    end
  end

endmodule

`default_nettype wire

// *** bvf_video_checker.sv ***
`timescale 1ns/1ns
`default_nettype none

// ====================================================================
// Port checker for the video fetch and dot path
module bvf_video_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic POWER_ON_CLEAR_N,
  input wire logic CLK_EN,
  input wire logic TIMING_CTRL_SELECT,
  input wire logic REGISTER_SELECT_BIT,
  input wire logic HOST_READ_NOT_WRITE,
  input wire logic HOST_DATA_BUS_OE,
  input wire logic CPU_OWNS_VIDEO_MEMORY,
  input wire logic [15:0] CPU_ADDRESS,
  input wire logic CPU_ACCESS_SELECT,
  input wire logic CLEAR_SCREEN_LINE,
  input wire logic [1:0] MEMORY_SIZE_OPTION,
  input wire logic [15:0] VIDEO_MEMORY_ADDRESS,
  input wire logic [7:0] DRAM_MUX_ADDRESS,
  input wire logic ROW_COLUMN_SELECT,
  input wire logic VIDEO_MEMORY_WRITE_EN,
  input wire logic CPU_WAIT,
  input wire logic PIXEL_LATCH_STROBE,
  input wire logic SHIFT_LOAD_N,
  input wire logic DISPLAY_WINDOW_ENABLE,
  input wire logic VSYNC_IRQ
);
  // Top memory bit the size option should pick; code 3 acts like the 64K setting.
  wire logic size_top;
  assign size_top = (MEMORY_SIZE_OPTION == 2'h1) ||
                    (MEMORY_SIZE_OPTION != 2'h2 && VIDEO_MEMORY_ADDRESS[15]);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N || !POWER_ON_CLEAR_N);

  // Dot sequencing; these assume the enable stays high, as the bench keeps it.
  strobe_load_a: assert property (PIXEL_LATCH_STROBE && CLK_EN |=> !SHIFT_LOAD_N)
    else $error("shifter load did not follow the latch strobe");
  load_period_a: assert property (!SHIFT_LOAD_N && CLK_EN |=> SHIFT_LOAD_N [*7] ##1 !SHIFT_LOAD_N)
    else $error("shifter load not once per eight dots");
  row_phase_a: assert property (!SHIFT_LOAD_N && CLK_EN |=>
      ROW_COLUMN_SELECT [*3] ##1 !ROW_COLUMN_SELECT [*5])
    else $error("row and column phases out of place");
  // The stability terms keep a lagging register stage from being blamed.
  dram_row_a: assert property (ROW_COLUMN_SELECT && $past(ROW_COLUMN_SELECT) &&
      $stable(VIDEO_MEMORY_ADDRESS) |-> DRAM_MUX_ADDRESS ==
      {VIDEO_MEMORY_ADDRESS[9:4], VIDEO_MEMORY_ADDRESS[1], VIDEO_MEMORY_ADDRESS[2]})
    else $error("row phase address bits wrong");
  size_top_a: assert property (!SHIFT_LOAD_N && $stable(VIDEO_MEMORY_ADDRESS) &&
      $stable(MEMORY_SIZE_OPTION) |-> DRAM_MUX_ADDRESS[7] == size_top)
    else $error("top memory bit does not follow the size option");
  cpu_addr_a: assert property (CPU_OWNS_VIDEO_MEMORY && CLK_EN |=>
      VIDEO_MEMORY_ADDRESS == $past(CPU_ADDRESS))
    else $error("processor address not passed to memory");
  read_mode_a: assert property (!CPU_ACCESS_SELECT && !CLEAR_SCREEN_LINE |=>
      !VIDEO_MEMORY_WRITE_EN)
    else $error("memory left read mode without a request");
  wait_block_a: assert property (CPU_WAIT |-> !VIDEO_MEMORY_WRITE_EN)
    else $error("processor write while the scan owns memory");
  irq_pulse_a: assert property (VSYNC_IRQ |-> !DISPLAY_WINDOW_ENABLE ##1 !VSYNC_IRQ)
    else $error("retrace interrupt not a single pulse in blanking");
  oe_cause_a: assert property (HOST_DATA_BUS_OE |-> $past(TIMING_CTRL_SELECT) &&
      $past(REGISTER_SELECT_BIT) && $past(HOST_READ_NOT_WRITE))
    else $error("read data driven without a selected read");
endmodule

bind bvf_video_top bvf_video_checker i_chk (.CLK_SYS, .RST_N, .POWER_ON_CLEAR_N, .CLK_EN,
  .TIMING_CTRL_SELECT, .REGISTER_SELECT_BIT, .HOST_READ_NOT_WRITE, .HOST_DATA_BUS_OE,
  .CPU_OWNS_VIDEO_MEMORY, .CPU_ADDRESS, .CPU_ACCESS_SELECT, .CLEAR_SCREEN_LINE,
  .MEMORY_SIZE_OPTION, .VIDEO_MEMORY_ADDRESS, .DRAM_MUX_ADDRESS, .ROW_COLUMN_SELECT,
  .VIDEO_MEMORY_WRITE_EN, .CPU_WAIT, .PIXEL_LATCH_STROBE, .SHIFT_LOAD_N,
  .DISPLAY_WINDOW_ENABLE, .VSYNC_IRQ);

`default_nettype wire

// *** bvf_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ====================================================================
// Host processor on the timing controller port
module bvf_host_model (
  input wire logic clk,
  output logic sel,
  output logic strobe,
  output logic rs,
  output logic rnw,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic oe
);
  // Idle with the strobe high, so every access shows a clean falling edge.
  initial begin
    sel = 1'b0;
    strobe = 1'b1;
    rs = 1'b0;
    rnw = 1'b1;
    wdata = 8'h00;
  end

  // One port cycle; callers send the index byte before the data byte.
  task automatic access(input logic s, input logic r, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    sel = s;
    rs = r;
    rnw = w;
    wdata = d;
    @(negedge clk);
    strobe = 1'b0;
    @(negedge clk);
    q = (oe === 1'b1) ? rdata : 8'hxx;
    strobe = 1'b1;
    @(negedge clk);
    // A released bus must not keep showing the old byte.
    sel = 1'b0;
    wdata = ~wdata;
  endtask
endmodule

`default_nettype wire

// *** test_bitmap_video_fetch_and_serializer.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

// ====================================================================
// Bench for the video fetch and dot path
module test_bitmap_video_fetch_and_serializer
  import bvf_pkg::*;
;
  logic clk, rst_n, poc_n, en, rs, rnw, sel, stb, own, acc, clr, rg, gg, bg, fill;
  logic oe, rcs, we, wt, pls, ldn, win, irq, ro, go, bo, pb, pr, vs;
  logic [7:0] wd, rd, rdat, gdat, bdat, dram, q;
  logic [15:0] cpu_a, vma;
  logic [1:0] opt;
  logic [15:0] atab [4] = '{16'h0000, 16'hFFFF, 16'h5A3C, 16'h8001};
  int errors, checked, n, hi;

  bvf_video_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(en), .POWER_ON_CLEAR_N(poc_n),
    .TIMING_CTRL_SELECT(sel), .BUS_PHASE_STROBE(stb), .REGISTER_SELECT_BIT(rs),
    .HOST_READ_NOT_WRITE(rnw), .HOST_DATA_BUS_IN(wd), .HOST_DATA_BUS_OUT(rd),
    .HOST_DATA_BUS_OE(oe), .CPU_OWNS_VIDEO_MEMORY(own), .CPU_ADDRESS(cpu_a),
    .CPU_ACCESS_SELECT(acc), .CLEAR_SCREEN_LINE(clr), .MEMORY_SIZE_OPTION(opt),
    .RED_PLANE_DATA(rdat), .GREEN_PLANE_DATA(gdat), .BLUE_PLANE_DATA(bdat),
    .RED_PLANE_GATE(rg), .GREEN_PLANE_GATE(gg), .BLUE_PLANE_GATE(bg), .SOLID_FILL(fill),
    .VIDEO_MEMORY_ADDRESS(vma), .DRAM_MUX_ADDRESS(dram), .ROW_COLUMN_SELECT(rcs),
    .VIDEO_MEMORY_WRITE_EN(we), .CPU_WAIT(wt), .PIXEL_LATCH_STROBE(pls), .SHIFT_LOAD_N(ldn),
    .DISPLAY_WINDOW_ENABLE(win), .HSYNC_OUT(), .VSYNC_OUT(vs), .VSYNC_IRQ(irq),
    .RED_OUTPUT(ro), .GREEN_OUTPUT(go), .BLUE_OUTPUT(bo));

  bvf_host_model i_host (.clk(clk), .sel(sel), .strobe(stb), .rs(rs), .rnw(rnw),
    .wdata(wd), .rdata(rd), .oe(oe));

  // Free-running system clock, 50 ns period.
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ==================================================================
  // Access tasks
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    i_host.access(1'b1, 1'b0, 1'b0, idx, q);
    i_host.access(1'b1, 1'b1, 1'b0, val, q);
  endtask

  task automatic rdreg(input logic [7:0] idx);
    i_host.access(1'b1, 1'b0, 1'b0, idx, q);
    i_host.access(1'b1, 1'b1, 1'b1, 8'h00, q);
  endtask

  // Follows the scan from the next window start; columns past the last shown freeze.
  task automatic scan_check(input int r0, input int r1, input int nrow, input int nline);
    int c;
    @(posedge win);
    for (int l = 0; l < nline; l++) begin
      for (int r = 0; r < nrow; r++) begin
        for (int k = 0; k <= r0; k++) begin
          c = (k < r1) ? k : r1 - 1;
          @(negedge clk iff ldn === 1'b0);
          opt = 2'(k);
          `CHK("scan address", {12'(l * r1 + c), 4'(r)}, vma)
        end
      end
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 19000 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("Error watchdog expected done seen hang");
    report_and_stop;
  end

  // ==================================================================
  // Test sequence
  initial begin
    {rst_n, own, acc, clr, bg, opt, cpu_a} = '0;
    {poc_n, en, rg, gg, fill} = 5'h1F;
    {rdat, gdat, bdat} = {8'hFF, 8'h00, 8'hAA};
    repeat (10) @(negedge clk);
    `CHK("reset outputs", 4'h8, {ldn, oe, irq, we})
    rst_n = 1'b1;
    scan_check(99, 80, 10, 2);
    $display("test default scan done");
    for (int i = 0; i <= 18; i++) begin
      rdreg(8'(i));
      `CHK("register reset value", (i < 18) ? BVF_REG_INIT[i] : 8'h00, q)
    end
    $display("test register reset values done");
    wr(8'h0C, 8'hA5);
    wr(8'h0D, 8'h5A);
    i_host.access(1'b0, 1'b1, 1'b0, 8'hFF, q);
    rdreg(8'h0D);
    `CHK("unselected write", 8'h5A, q)
    i_host.access(1'b1, 1'b1, 1'b1, 8'h00, q);
    `CHK("read leaves value", 8'h5A, q)
    rdreg(8'h0C);
    `CHK("indexed register", 8'hA5, q)
    poc_n = 1'b0;
    @(negedge clk);
    poc_n = 1'b1;
    rdreg(8'h0C);
    `CHK("clear restores", 8'h00, q)
    $display("test host port done");
    // Total first, so the running column never overtakes the new line length.
    wr(8'h00, 8'h09);
    wr(8'h09, 8'h01);
    wr(8'h04, 8'h02);
    wr(8'h07, 8'h02);
    wr(8'h06, 8'h02);
    wr(8'h01, 8'h04);
    wr(8'h0F, 8'hFF);
    @(posedge irq);
    // The sync output rises one cycle after the interrupt pulse starts.
    repeat (2) @(negedge clk);
    `CHK("vertical sync", 1'b1, vs)
    scan_check(9, 4, 2, 2);
    scan_check(9, 4, 1, 1);
    $display("test small frame done");
    hi = 0;
    repeat (480) begin
      @(negedge clk);
      `CHK("blue gated off", 1'b0, bo)
      `CHK("solid fill", ro, go)
      hi += int'(ro);
    end
    `CHK("red shown and blanked", 1'b1, hi > 0 && hi < 480)
    @(posedge win);
    n = 0;
    while (ro !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("blanking delay", 1'b1, n >= 15 && n <= 18)
    // Solid fill off, or it would mask the blue dot pattern.
    {bg, fill} = 2'b10;
    repeat (20) @(negedge clk);
    repeat (200) begin
      pb = bo;
      pr = ro;
      @(negedge clk);
      if (ro === 1'b1 && pr === 1'b1) `CHK("dot stream", ~pb, bo)
    end
    // Cursor on character 1 of the top line; green has no dots of its own.
    wr(8'h0F, 8'h01);
    repeat (20) @(negedge clk);
    hi = 0;
    // 480 cycles are exactly one small frame: two shown rows carry the cursor.
    repeat (480) begin
      @(negedge clk);
      hi += int'(go);
    end
    `CHK("cursor dots", 2 * BVF_DOTS_PER_CHAR, hi)
    $display("test colour gating done");
    // Start just inside a four-character window, so the scan owns memory.
    @(posedge win);
    @(negedge clk);
    own = 1'b1;
    acc = 1'b1;
    foreach (atab[i]) begin
      cpu_a = atab[i];
      clr = i[0];
      @(negedge clk);
      `CHK("cpu address", atab[i], vma)
      `CHK("cpu wait", 1'b1, wt)
      `CHK("cpu write held", 1'b0, we)
    end
    // Once the window closes the waiting write goes through.
    @(negedge win);
    @(negedge clk);
    `CHK("cpu write", 1'b1, we)
    `CHK("cpu wait released", 1'b0, wt)
    {own, acc, clr} = 3'h0;
    $display("test processor address done");
    report_and_stop;
  end
endmodule

`default_nettype wire
